// file: rtl/lpwm_regs.svh
// register offsets, field positions and reset values of the led pwm block
// assumes: included by bare name after the package
`ifndef LPWM_REGS_SVH
`define LPWM_REGS_SVH

// ==========================================================
// register map
`define LPWM_MODE_ADDR   8'h01
`define LPWM_CH_FIRST    8'h06
`define LPWM_CH_LAST     8'h45
`define LPWM_MODE_RST    8'h04
`define LPWM_MODE_MASK   8'h1f

// ==========================================================
// output_mode_control fields
`define LPWM_INVERT_BIT  4
`define LPWM_UPDATE_BIT  3
`define LPWM_DRIVER_BIT  2
`define LPWM_DIS_HI_BIT  1
`define LPWM_DIS_LO_BIT  0

// ==========================================================
// counter
`define LPWM_CNT_LAST    12'hfff
`define LPWM_CNT_FIRST   12'h000

`endif

// file: rtl/lpwm_pkg.sv
// types of the led pwm block: serial-bus states, count sets, module state
// assumes: nothing outside itself
package lpwm_pkg;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_AACK = 9'h004,
    S_REG  = 9'h008,
    S_RACK = 9'h010,
    S_WDAT = 9'h020,
    S_WACK = 9'h040,
    S_RDAT = 9'h080,
    S_MACK = 9'h100
  } lpwm_bus_st_t;

  typedef struct packed {
    logic [15:0][11:0] on;
    logic [15:0][11:0] off;
  } lpwm_cnt_t;

  typedef struct packed {
    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    lpwm_bus_st_t      st;
    logic [3:0]        bitc;
    logic [7:0]        sh;
    logic [7:0]        ptr;
    logic              rw;
    logic              nack;
    logic              sda_low;
    logic [7:0]        mode;
    lpwm_cnt_t         stage;
    lpwm_cnt_t         appl;
    logic [15:0][3:0]  wmask;
    logic [15:0]       pend;
    logic              chg;
    logic              req_tg;
    logic [1:0]        ack_s;
  } lpwm_sys_t;

  typedef struct packed {
    logic [11:0]       cnt;
    logic [15:0]       out;
    logic [1:0]        oe_s;
    logic [1:0][4:0]   mode_s;
    logic [1:0]        req_s;
    logic              ack_tg;
    lpwm_cnt_t         act;
    logic [15:0]       pin_o;
    logic [15:0]       pin_oe;
  } lpwm_pwm_t;

endpackage : lpwm_pkg

// file: rtl/lpwm_top.sv
// sixteen channel 12-bit led pwm engine behind a two-wire serial slave
// assumes: scl/sda and output enable are async pins; pwm clock unrelated
// How it works
// - enabled outputs follow the waveform, inverted when the invert bit is set
// - with update bit clear, channel counts apply only at bus stop
// - with update bit set, counts apply at a byte acknowledge
// - acknowledge mode applies a channel after all four of its bytes
// - driver bit picks open-drain or totem-pole for all channels
// - disabled with field 00 drives every output low
// - disabled with field 01 drives high on totem-pole, else floats
// - disabled with upper field bit set floats every output
// - every channel has its own turn-on and turn-off count
// - both counts are 12-bit values loaded by the host
// - one shared 12-bit counter runs 0 to fff and wraps
// - output rises at turn-on count, falls at turn-off count
// - edges are placed to one counter step
// - turn-off below turn-on ends the pulse in the next frame
// - low byte holds eight low bits, high byte four high bits
`timescale 1ns/1ps
`include "lpwm_regs.svh"

module lpwm_top
  import lpwm_pkg::*;
#(
  parameter int         CH_N     = 16,
  parameter logic [6:0] BUS_ADDR = 7'h40
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_pwm,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  input  wire logic        i_output_enable_n,
  output logic [15:0]      o_channel_output,
  output logic [15:0]      o_channel_output_oe
);

  if (CH_N != 16) begin : g_chk
    $error("lpwm_top serves exactly sixteen channels");
  end

  // ==========================================================
  // byte access to the channel and mode registers
  function automatic logic [7:0] rd_byte(input lpwm_sys_t s, input logic [7:0] a);
    logic [7:0] idx;
    idx = a - `LPWM_CH_FIRST;
    rd_byte = 8'h00;
    if (a == `LPWM_MODE_ADDR) begin
      rd_byte = s.mode;
    end else if (a >= `LPWM_CH_FIRST && a <= `LPWM_CH_LAST) begin
      case (idx[1:0])
        2'd0:    rd_byte = s.stage.on[idx[5:2]][7:0];
        2'd1:    rd_byte = {4'h0, s.stage.on[idx[5:2]][11:8]};
        2'd2:    rd_byte = s.stage.off[idx[5:2]][7:0];
        default: rd_byte = {4'h0, s.stage.off[idx[5:2]][11:8]};
      endcase
    end
  endfunction : rd_byte

  lpwm_sys_t  s_ff, nxt_s;
  lpwm_pwm_t  p_ff, nxt_p;
  logic       scl_rise, scl_fall, bus_start, bus_stop, busy;
  logic [7:0] idx;
  logic [7:0] rd;

  assign scl_rise  = s_ff.scl_s[1] & ~s_ff.scl_s[2];
  assign scl_fall  = ~s_ff.scl_s[1] & s_ff.scl_s[2];
  assign bus_start = s_ff.scl_s[1] & s_ff.scl_s[2] & s_ff.sda_s[2] & ~s_ff.sda_s[1];
  assign bus_stop  = s_ff.scl_s[1] & s_ff.scl_s[2] & ~s_ff.sda_s[2] & s_ff.sda_s[1];
  // a new snapshot waits until the pwm side has taken the last one
  assign busy      = s_ff.req_tg != s_ff.ack_s[1];
  assign idx       = s_ff.ptr - `LPWM_CH_FIRST;
  assign rd        = rd_byte(s_ff, s_ff.ptr);

  // ==========================================================
  // system domain: serial slave, staging and update point
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.scl_s = {s_ff.scl_s[1:0], i_scl};
    nxt_s.sda_s = {s_ff.sda_s[1:0], i_sda};
    nxt_s.ack_s = {s_ff.ack_s[0], p_ff.ack_tg};
    // snapshot first so a pending bit set this cycle is not lost
    if (!busy && (s_ff.pend != 16'h0000)) begin
      for (int i = 0; i < 16; i++) begin
        if (s_ff.pend[i]) begin
          nxt_s.appl.on[i]  = s_ff.stage.on[i];
          nxt_s.appl.off[i] = s_ff.stage.off[i];
        end
      end
      nxt_s.pend   = 16'h0000;
      nxt_s.req_tg = ~s_ff.req_tg;
    end
    if (bus_start) begin
      nxt_s.st      = S_ADDR;
      nxt_s.bitc    = 4'd0;
      nxt_s.sda_low = 1'b0;
    end else if (bus_stop) begin
      nxt_s.st      = S_IDLE;
      nxt_s.sda_low = 1'b0;
      if (!s_ff.mode[`LPWM_UPDATE_BIT] && s_ff.chg) begin
        nxt_s.pend  = 16'hffff;
        nxt_s.chg   = 1'b0;
        nxt_s.wmask = '0;
      end
    end else if (scl_rise) begin
      if (s_ff.st == S_ADDR || s_ff.st == S_REG || s_ff.st == S_WDAT) begin
        nxt_s.sh   = {s_ff.sh[6:0], s_ff.sda_s[1]};
        nxt_s.bitc = s_ff.bitc + 4'd1;
      end else if (s_ff.st == S_MACK) begin
        nxt_s.nack = s_ff.sda_s[1];
      end
    end else if (scl_fall) begin
      case (s_ff.st)
        S_ADDR: begin
          if (s_ff.bitc == 4'd8) begin
            if (s_ff.sh[7:1] == BUS_ADDR) begin
              nxt_s.st      = S_AACK;
              nxt_s.rw      = s_ff.sh[0];
              nxt_s.sda_low = 1'b1;
            end else begin
              nxt_s.st = S_IDLE;
            end
          end
        end
        S_REG: begin
          if (s_ff.bitc == 4'd8) begin
            nxt_s.ptr     = s_ff.sh;
            nxt_s.st      = S_RACK;
            nxt_s.sda_low = 1'b1;
          end
        end
        S_WDAT: begin
          if (s_ff.bitc == 4'd8) begin
            nxt_s.st      = S_WACK;
            nxt_s.sda_low = 1'b1;
            nxt_s.ptr     = s_ff.ptr + 8'd1;
            if (s_ff.ptr == `LPWM_MODE_ADDR) begin
              nxt_s.mode = s_ff.sh & `LPWM_MODE_MASK;
            end else if (s_ff.ptr >= `LPWM_CH_FIRST && s_ff.ptr <= `LPWM_CH_LAST) begin
              case (idx[1:0])
                2'd0:    nxt_s.stage.on[idx[5:2]][7:0]   = s_ff.sh;
                2'd1:    nxt_s.stage.on[idx[5:2]][11:8]  = s_ff.sh[3:0];
                2'd2:    nxt_s.stage.off[idx[5:2]][7:0]  = s_ff.sh;
                default: nxt_s.stage.off[idx[5:2]][11:8] = s_ff.sh[3:0];
              endcase
              nxt_s.chg = 1'b1;
              nxt_s.wmask[idx[5:2]][idx[1:0]] = 1'b1;
              if (s_ff.mode[`LPWM_UPDATE_BIT] &&
                  ((s_ff.wmask[idx[5:2]] | (4'h1 << idx[1:0])) == 4'hf)) begin
                nxt_s.pend[idx[5:2]]  = 1'b1;
                nxt_s.wmask[idx[5:2]] = 4'h0;
              end
            end
          end
        end
        S_AACK: begin
          nxt_s.bitc = 4'd0;
          if (s_ff.rw) begin
            nxt_s.st      = S_RDAT;
            nxt_s.sh      = rd;
            nxt_s.sda_low = ~rd[7];
            nxt_s.ptr     = s_ff.ptr + 8'd1;
          end else begin
            nxt_s.st      = S_REG;
            nxt_s.sda_low = 1'b0;
          end
        end
        S_RACK, S_WACK: begin
          nxt_s.st      = S_WDAT;
          nxt_s.bitc    = 4'd0;
          nxt_s.sda_low = 1'b0;
        end
        S_RDAT: begin
          if (s_ff.bitc == 4'd7) begin
            nxt_s.st      = S_MACK;
            nxt_s.sda_low = 1'b0;
          end else begin
            nxt_s.sh      = {s_ff.sh[6:0], 1'b0};
            nxt_s.sda_low = ~s_ff.sh[6];
            nxt_s.bitc    = s_ff.bitc + 4'd1;
          end
        end
        S_MACK: begin
          if (s_ff.nack) begin
            nxt_s.st = S_IDLE;
          end else begin
            nxt_s.st      = S_RDAT;
            nxt_s.bitc    = 4'd0;
            nxt_s.sh      = rd;
            nxt_s.sda_low = ~rd[7];
            nxt_s.ptr     = s_ff.ptr + 8'd1;
          end
        end
        default: nxt_s.st = s_ff.st;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_ff       <= '0;
      s_ff.scl_s <= 3'h7;
      s_ff.sda_s <= 3'h7;
      s_ff.st    <= S_IDLE;
      s_ff.mode  <= `LPWM_MODE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = s_ff.sda_low;

  // ==========================================================
  // pwm domain: counter, comparators and pin drivers
  always_comb begin
    logic [4:0] m;
    logic       v;
    m            = p_ff.mode_s[1];
    v            = 1'b0;
    nxt_p        = p_ff;
    nxt_p.oe_s   = {p_ff.oe_s[0], i_output_enable_n};
    // mode bits change rarely and each acts alone, so per-bit sync suffices
    nxt_p.mode_s = {p_ff.mode_s[0], s_ff.mode[4:0]};
    nxt_p.req_s  = {p_ff.req_s[0], s_ff.req_tg};
    if (p_ff.req_s[1] != p_ff.ack_tg) begin
      nxt_p.act    = s_ff.appl;
      nxt_p.ack_tg = p_ff.req_s[1];
    end
    nxt_p.cnt = p_ff.cnt + 12'd1;
    for (int i = 0; i < 16; i++) begin
      if (p_ff.cnt == p_ff.act.off[i]) begin
        nxt_p.out[i] = 1'b0;
      end else if (p_ff.cnt == p_ff.act.on[i]) begin
        nxt_p.out[i] = 1'b1;
      end
      v = p_ff.out[i] ^ m[`LPWM_INVERT_BIT];
      if (!p_ff.oe_s[1]) begin
        nxt_p.pin_o[i]  = m[`LPWM_DRIVER_BIT] & v;
        nxt_p.pin_oe[i] = m[`LPWM_DRIVER_BIT] | ~v;
      end else if (m[`LPWM_DIS_HI_BIT]) begin
        nxt_p.pin_o[i]  = 1'b0;
        nxt_p.pin_oe[i] = 1'b0;
      end else if (m[`LPWM_DIS_LO_BIT]) begin
        nxt_p.pin_o[i]  = m[`LPWM_DRIVER_BIT];
        nxt_p.pin_oe[i] = m[`LPWM_DRIVER_BIT];
      end else begin
        nxt_p.pin_o[i]  = 1'b0;
        nxt_p.pin_oe[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_pwm or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p_ff        <= '0;
      p_ff.oe_s   <= 2'h3;
      p_ff.mode_s <= {2{5'h04}};
    end else begin
      p_ff <= nxt_p;
    end
  end

  assign o_channel_output    = p_ff.pin_o;
  assign o_channel_output_oe = p_ff.pin_oe;

  // ==========================================================
  // checks
  a_cnt_wrap: assert property (@(posedge i_clk_pwm) disable iff (!i_reset_n)
    p_ff.cnt == `LPWM_CNT_LAST |=> p_ff.cnt == `LPWM_CNT_FIRST)
    else $error("counter did not wrap");
  a_edge_on: assert property (@(posedge i_clk_pwm) disable iff (!i_reset_n)
    (p_ff.cnt == p_ff.act.on[0] && p_ff.cnt != p_ff.act.off[0]) |=> p_ff.out[0])
    else $error("channel did not turn on");
  a_edge_off: assert property (@(posedge i_clk_pwm) disable iff (!i_reset_n)
    p_ff.cnt == p_ff.act.off[0] |=> !p_ff.out[0] ##1 (!p_ff.out[0] || $past(p_ff.cnt) == p_ff.act.on[0]))
    else $error("channel did not turn off");
  a_frame_wrap: assert property (@(posedge i_clk_pwm) disable iff (!i_reset_n)
    (p_ff.act.off[0] < p_ff.act.on[0] && p_ff.out[0] && p_ff.cnt == `LPWM_CNT_LAST
     && p_ff.req_s[1] == p_ff.ack_tg) |=> p_ff.out[0])
    else $error("pulse ended at frame wrap");
  a_invert_en: assert property (@(posedge i_clk_pwm) disable iff (!i_reset_n)
    (!p_ff.oe_s[1] && p_ff.mode_s[1][2]) |=>
    o_channel_output[0] == ($past(p_ff.out[0]) ^ $past(p_ff.mode_s[1][4])))
    else $error("enabled output polarity wrong");
  a_od_never_high: assert property (@(posedge i_clk_pwm) disable iff (!i_reset_n)
    (!p_ff.oe_s[1] && !p_ff.mode_s[1][2]) |=> o_channel_output == 16'h0000)
    else $error("open-drain output driven high");
  a_dis_low: assert property (@(posedge i_clk_pwm) disable iff (!i_reset_n)
    (p_ff.oe_s[1] && p_ff.mode_s[1][1:0] == 2'h0) |=>
    (o_channel_output == 16'h0000 && o_channel_output_oe == 16'hffff))
    else $error("disabled outputs not low");
  a_dis_high: assert property (@(posedge i_clk_pwm) disable iff (!i_reset_n)
    (p_ff.oe_s[1] && p_ff.mode_s[1][1:0] == 2'h1) |=>
    o_channel_output_oe == {16{$past(p_ff.mode_s[1][2])}})
    else $error("disabled outputs not high or floating");
  a_dis_float: assert property (@(posedge i_clk_pwm) disable iff (!i_reset_n)
    (p_ff.oe_s[1] && p_ff.mode_s[1][1]) |=> o_channel_output_oe == 16'h0000)
    else $error("disabled outputs not floating");
  a_stop_apply: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (bus_stop && !s_ff.mode[3] && s_ff.chg) |=> s_ff.pend == 16'hffff)
    else $error("stop did not schedule update");
  a_hold_counts: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_ff.pend == 16'h0000 |=> $stable(s_ff.appl))
    else $error("counts changed without update point");

endmodule : lpwm_top

// file: bench/lpwm_host_model.sv
// serial bus host: scl push-pull, sda pulled low or released
// assumes: bench resolves the sda wire with a pull-up
`timescale 1ns/1ps
module lpwm_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic hc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : hc

  // ==========================================================
  // bus primitives, each phase 8 sys clocks, above the minimum of 4
  task automatic bus_start;
    o_sda_low = 1'b0;
    hc(8);
    o_scl = 1'b1;
    hc(8);
    o_sda_low = 1'b1;
    hc(8);
    o_scl = 1'b0;
    hc(8);
  endtask : bus_start

  task automatic bus_stop;
    o_sda_low = 1'b1;
    hc(8);
    o_scl = 1'b1;
    hc(8);
    o_sda_low = 1'b0;
    hc(8);
  endtask : bus_stop

  // ninth bit sent as 1: released for ack, or a nack when reading
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      o_sda_low = ~tx[i];
      hc(8);
      o_scl = 1'b1;
      hc(4);
      rx[i] = i_sda;
      hc(4);
      o_scl = 1'b0;
    end
    q = rx[8:1];
    ack = ~rx[0];
  endtask : xfer
endmodule : lpwm_host_model

// file: bench/led_pwm_phase_output_control_tb.sv
// bench for the led pwm block: host model on the serial pins
// assumes: bus address 7'h40, sda pulled high, pins read via oe
`timescale 1ns/1ps
`include "lpwm_regs.svh"
module led_pwm_phase_output_control_tb;
  logic        clk_sys;
  logic        clk_pwm;
  logic        reset_n;
  logic        scl;
  logic        sda_low;
  logic        sda;
  logic        sda_oe;
  logic        sda_o;
  logic        oe_n;
  logic [15:0] ch_out;
  logic [15:0] ch_oe;
  int          n_mismatch;
  int          checked;

  // device side is open drain: enabled data level or the pull-up
  assign sda = (sda_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

  lpwm_top dut (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_clk_pwm(clk_pwm),
    .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_output_enable_n(oe_n), .o_channel_output(ch_out), .o_channel_output_oe(ch_oe));

  lpwm_host_model host (.i_clk_sys(clk_sys), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // pwm clock offset by 7 ns, yet its edges still meet sys edges every 800 ns, from 775 ns
  initial begin
    clk_pwm = 1'b0;
    #7;
    forever #32 clk_pwm = ~clk_pwm;
  end

  // ==========================================================
  // checking and bus helpers
  task automatic complete_run;
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // leaves the transfer open unless fin is set
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$], input bit fin);
    logic [7:0] q;
    logic       a;
    host.bus_start();
    host.xfer({7'h40, 1'b0}, q, a);
    chk("addr ack", {15'h0, a}, 16'h1);
    host.xfer(p, q, a);
    foreach (d[i]) host.xfer(d[i], q, a);
    if (fin) host.bus_stop();
  endtask : wr

  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    logic a;
    host.bus_start();
    host.xfer({7'h40, 1'b0}, q, a);
    host.xfer(p, q, a);
    host.bus_start();
    host.xfer({7'h40, 1'b1}, q, a);
    host.xfer(8'hff, q, a);
    host.bus_stop();
  endtask : rd

  task automatic wt(input int ch, input logic lv, input int lim, output int n);
    n = 0;
    while (ch_out[ch] !== lv && n < lim) begin
      @(posedge clk_pwm);
      #1;
      n++;
    end
  endtask : wt

  task automatic meas(input int ch, output int hi, output int lo);
    int n;
    wt(ch, 1'b0, 4200, n);
    wt(ch, 1'b1, 4200, n);
    wt(ch, 1'b0, 4200, hi);
    wt(ch, 1'b1, 4200, lo);
    if (n == 4200 || hi == 4200 || lo == 4200) begin
      n_mismatch++;
      $display("MISMATCH pulse wait exp edge seen none");
      complete_run();
    end
  endtask : meas

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] q;
    logic       a;
    rd(`LPWM_MODE_ADDR, q);
    chk("mode reset", {8'h0, q}, {8'h0, `LPWM_MODE_RST});
    host.bus_start();
    host.xfer({7'h41, 1'b0}, q, a);
    host.bus_stop();
    chk("foreign addr", {15'h0, a}, 16'h0);
    wr(`LPWM_MODE_ADDR, '{8'hff}, 1);
    rd(`LPWM_MODE_ADDR, q);
    chk("mode ro bits", {8'h0, q}, 16'h001f);
    $display("done regs");
  endtask : t_regs

  task automatic t_pins;
    logic [7:0]  md[9] = '{8'h04, 8'h05, 8'h01, 8'h06, 8'h07, 8'h02, 8'h14, 8'h00, 8'h10};
    logic [15:0] eo[9] = '{16'hffff, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h0,
                           16'hffff, 16'hffff, 16'h0};
    logic [15:0] ev[9] = '{16'h0, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffff,
                           16'h0, 16'h0};
    for (int i = 0; i < 9; i++) begin
      @(negedge clk_sys);
      oe_n = (i < 6);
      wr(`LPWM_MODE_ADDR, '{md[i]}, 1);
      repeat (8) @(posedge clk_pwm);
      #1;
      chk("pin oe", ch_oe, eo[i]);
      if (eo[i] == 16'hffff) chk("pin out", ch_out, ev[i]);
    end
    $display("done pins");
  endtask : t_pins

  task automatic t_stop_mode;
    int hi;
    int lo;
    int n;
    wr(`LPWM_MODE_ADDR, '{8'h04}, 1);
    wr(`LPWM_CH_FIRST, '{8'h99, 8'h01, 8'hcc, 8'h04}, 0);
    wt(0, 1'b1, 4200, n);
    chk("held to stop", n[15:0], 16'd4200);
    host.bus_stop();
    meas(0, hi, lo);
    chk("width", hi[15:0], 16'd819);
    chk("period", 16'(hi + lo), 16'd4096);
    wr(8'h08, '{8'hcb, 8'h0c}, 0);
    wr(8'h06, '{8'h65, 8'h0e}, 0);
    meas(0, hi, lo);
    chk("old width", hi[15:0], 16'd819);
    host.bus_stop();
    repeat (4200) @(posedge clk_pwm);
    meas(0, hi, lo);
    chk("wrap width", hi[15:0], 16'd3686);
    chk("wrap period", 16'(hi + lo), 16'd4096);
    $display("done stop mode");
  endtask : t_stop_mode

  task automatic t_ack_mode;
    logic [7:0] q;
    int hi;
    int lo;
    int n;
    wr(`LPWM_MODE_ADDR, '{8'h0c}, 1);
    wr(8'h0a, '{8'h00, 8'h01, 8'h00}, 1);
    wt(1, 1'b1, 4200, n);
    chk("partial set", n[15:0], 16'd4200);
    // upper nibble set on purpose: only bits 3:0 of a high byte count
    wr(8'h0d, '{8'hf2}, 0);
    meas(1, hi, lo);
    chk("ack width", hi[15:0], 16'd256);
    host.bus_stop();
    rd(8'h0d, q);
    chk("high byte", {8'h0, q}, 16'h0002);
    $display("done ack mode");
  endtask : t_ack_mode

  initial begin
    n_mismatch = 0;
    checked = 0;
    oe_n = 1'b1;
    reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (8) @(posedge clk_pwm);
    #1;
    chk("reset oe", ch_oe, 16'hffff);
    chk("reset out", ch_out, 16'h0);
    t_regs();
    t_pins();
    t_stop_mode();
    t_ack_mode();
    complete_run();
  end
endmodule : led_pwm_phase_output_control_tb
